// [inc/grab_regs_pkg.sv]
/*
 * Constants, field layouts and carriers for the buffered coefficient set and
 * the video measurement (line freeze and pixel grab) register segment.
 * Assumes an 8-bit register port addressed by the register offsets below.
 */
package grab_regs_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_U_GAIN_LOW = 8'h29;
    localparam logic [7:0] ADDR_V_GAIN_LOW = 8'h2a;
    localparam logic [7:0] ADDR_GAIN_HIGH = 8'h2b;
    localparam logic [7:0] ADDR_LUMA_OFFSET_LOW = 8'h2c;
    localparam logic [7:0] ADDR_OFFSET_MSB = 8'h2d;
    localparam logic [7:0] ADDR_PHASE_LOW = 8'h2e;
    localparam logic [7:0] ADDR_PHASE_HIGH = 8'h2f;
    localparam logic [7:0] ADDR_GRAB_CONTROL = 8'h30;
    localparam logic [7:0] ADDR_PIXEL_NUM_LOW = 8'h31;
    localparam logic [7:0] ADDR_LINE_NUM_LOW = 8'h32;
    localparam logic [7:0] ADDR_GRAB_NUM_HIGH = 8'h33;
    localparam logic [7:0] ADDR_RES_GY = 8'h34;
    localparam logic [7:0] ADDR_RES_BU = 8'h35;
    localparam logic [7:0] ADDR_RES_RV = 8'h36;
    localparam logic [7:0] ADDR_RES_RGB_LSB = 8'h37;
    localparam logic [7:0] ADDR_RES_LUMA = 8'h38;
    localparam logic [7:0] ADDR_RES_MSYNC = 8'h39;
    localparam logic [7:0] ADDR_RES_U = 8'h3a;
    localparam logic [7:0] ADDR_RES_V = 8'h3b;
    localparam logic [7:0] ADDR_RES_YUV_LSB = 8'h3c;

    // Reset value of every writable register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Writable-bit masks; reserved bits are dropped on write
    localparam logic [7:0] GAIN_HIGH_MASK = 8'hfb;
    localparam logic [7:0] OFFSET_MSB_MASK = 8'h07;
    localparam logic [7:0] GRAB_CONTROL_MASK = 8'h37;
    localparam logic [7:0] GRAB_NUM_HIGH_MASK = 8'h7f;

    // Field positions
    localparam int GH_LUMA_LSB = 6;
    localparam int GH_U_LSB = 3;
    localparam int GH_V_LSB = 0;
    localparam int OM_OFFSET_MSB_BIT = 2;
    localparam int OM_SYNC_LSB = 0;
    localparam int PL_VFLIP_BIT = 0;
    localparam int PL_PHASE_LSB = 1;
    localparam int GC_FLAG_BIT = 6;
    localparam int GC_FREEZE_BIT = 5;
    localparam int GC_EXT_LINE_BIT = 4;
    localparam int GC_GATE_BIT = 2;
    localparam int GC_PIX_EN_BIT = 1;
    localparam int GC_EXT_PIX_BIT = 0;
    localparam int GN_PIX_LSB = 0;
    localparam int GN_LINE_BIT = 3;
    localparam int GN_FIELD_LSB = 4;

    // Widths
    localparam int SAMPLE_W = 10;
    localparam int PIX_NUM_W = 11;
    localparam int LINE_NUM_W = 9;
    localparam int FIELD_NUM_W = 3;
    localparam int LOOP_W = 16;

    typedef struct packed {
        logic [9:0] luma_gain;
        logic [10:0] u_channel_gain;
        logic [9:0] v_channel_gain;
        logic [9:0] mixed_sync_gain;
        logic [8:0] luma_offset;
        logic [14:0] system_phase_offset;
        logic v_axis_flip;
    } coef_set_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] gy;
        logic [SAMPLE_W-1:0] bu;
        logic [SAMPLE_W-1:0] rv;
        logic [SAMPLE_W-1:0] luma;
        logic [SAMPLE_W-1:0] msync;
        logic [SAMPLE_W-1:0] u;
        logic [SAMPLE_W-1:0] v;
    } grab_sample_t;

    typedef struct packed {
        logic [LOOP_W-1:0] phase;
        logic [LOOP_W-1:0] freq;
    } loop_state_t;

endpackage

// [hdl/grab_pulse_select.sv]
/*
 * Picks the grab pulse from the external strobe pin or from an internal decode.
 * Assumes the strobe pin is synchronous to core_clk; its rising edge is the pulse.
 */
module grab_pulse_select
    import grab_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Selection
    input wire logic ext_select,
    input wire logic strobe_pin,
    input wire logic internal_pulse,
    // Result
    output logic pulse
);

    logic strobe_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strobe_q <= 1'b0;
        end else if (ce) begin
            strobe_q <= strobe_pin;
        end
    end

    // Edge detect so a held strobe grabs once
    assign pulse = ext_select ? (strobe_pin & ~strobe_q) : internal_pulse;

endmodule

// [hdl/pixel_sample_store.sv]
/*
 * Holds the captured pixel of every measured video signal.
 * Assumes capture is a one-cycle pulse qualified by the caller.
 */
module pixel_sample_store
    import grab_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Capture
    input wire logic capture,
    input wire grab_sample_t sample_in,
    // Held values
    output grab_sample_t sample_q
);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_q <= '0;
        end else if (ce && capture) begin
            sample_q <= sample_in;
        end
    end

    AST_SAMPLE_HELD: assert property (@(posedge core_clk) disable iff (rst)
        !(ce && capture) |=> $stable(sample_q)) else $error("sample changed without capture");

endmodule

// [hdl/scaler_phase_and_grab_registers.sv]
/*
 * Register segment for the buffered output-matrix set and the video
 * measurement controls: line freeze with loop-state hold, and pixel grab.
 * Assumes line/field/pixel counters and the tracking loop state come from the
 * decoder core on core_clk, and that the strobe and bank-select pins are
 * synchronous to core_clk.
 */
// The implementer's own choice: the address-and-strobe port.
// Function
// - U gain is 11 bits: own low byte plus gain-high bits 5-3.
// - V gain is 10 bits: own low byte plus gain-high bits 1-0.
// - Luma gain top two bits come from gain-high bits 7-6.
// - Luma offset is 9 bits: offset byte plus bit 2 of next register.
// - Mixed-sync gain top two bits come from offset-MSB bits 1-0.
// - Phase offset is 15 bits: low register bits 7-1, high register all bits.
// - Bit 0 of low phase register flips the V axis sign.
// - This buffered set is used only while bank select pin is high.
// - Flag sets when a line is grabbed with freeze enable high; no further grab until software clears.
// - With freeze enable high, freeze the line store at programmed line and field.
// - Store loop phase and frequency; reload synthesizer each line until flag clears.
// - With freeze enable low, no freeze; line grab only gates pixel grab.
// - External line select picks strobe pin, else internal line decode.
// - Gate plus pixel enable restricts pixel grab to the grabbed line and field.
// - Pixel enable captures all signals once per line at programmed pixel.
// - Pixel enable low holds captured values and ignores grab pulses.
// - External pixel select picks strobe pin, else internal pixel decode.
// - Pixel grab number low byte comes from pixel-number low register.
// - Line grab number low byte comes from line-number low register.
// - Upper pixel bits, line msb and field number come from next register.
// - Captured values are read only through the read-only result registers.
// - Luma gain low byte comes from the preceding register.
// - Mixed-sync gain low byte comes from an earlier register.
module scaler_phase_and_grab_registers
    import grab_regs_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Low bytes held in neighbouring registers
    input wire logic [7:0] luma_gain_low,
    input wire logic [7:0] mixed_sync_gain_low,
    // Pins
    input wire logic bank_select,
    input wire logic grab_strobe,
    // Decoder timing
    input wire logic line_start,
    input wire logic [LINE_NUM_W-1:0] line_count,
    input wire logic [FIELD_NUM_W-1:0] field_count,
    input wire logic [PIX_NUM_W-1:0] pixel_count,
    // Tracking loop and video samples
    input wire loop_state_t loop_state,
    input wire grab_sample_t video_sample,
    // Buffered coefficient set
    output coef_set_t coef_set,
    output logic coef_set_active,
    // Line freeze
    output logic line_store_freeze,
    output logic synth_reload,
    output loop_state_t frozen_loop_state
);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic [7:0] u_gain_low_q;
    logic [7:0] v_gain_low_q;
    logic [7:0] gain_high_q;
    logic [7:0] luma_offset_low_q;
    logic [7:0] offset_msb_q;
    logic [7:0] phase_low_q;
    logic [7:0] phase_high_q;
    logic [7:0] grab_control_q;
    logic [7:0] pixel_num_low_q;
    logic [7:0] line_num_low_q;
    logic [7:0] grab_num_high_q;
    logic line_grab_flag_q;
    logic line_window_q;
    logic [7:0] rdata_q;
    coef_set_t coef_d;
    coef_set_t coef_q;
    loop_state_t frozen_q;
    grab_sample_t held;
    logic [PIX_NUM_W-1:0] pixel_grab_number;
    logic [LINE_NUM_W-1:0] line_grab_number;
    logic [FIELD_NUM_W-1:0] field_grab_number;
    logic line_freeze_enable;
    logic external_line_grab_select;
    logic pixel_grab_gate;
    logic pixel_capture_enable;
    logic external_pixel_grab_select;
    logic line_decode;
    logic pixel_decode;
    logic line_pulse;
    logic pixel_pulse;
    logic freeze_grab;
    logic flag_clear;
    logic pixel_capture;
    logic [7:0] read_d;

    assign line_freeze_enable = grab_control_q[GC_FREEZE_BIT];
    assign external_line_grab_select = grab_control_q[GC_EXT_LINE_BIT];
    assign pixel_grab_gate = grab_control_q[GC_GATE_BIT];
    assign pixel_capture_enable = grab_control_q[GC_PIX_EN_BIT];
    assign external_pixel_grab_select = grab_control_q[GC_EXT_PIX_BIT];

    // Programmed grab position
    assign pixel_grab_number = {grab_num_high_q[GN_PIX_LSB +: 3], pixel_num_low_q};
    assign line_grab_number = {grab_num_high_q[GN_LINE_BIT], line_num_low_q};
    assign field_grab_number = grab_num_high_q[GN_FIELD_LSB +: FIELD_NUM_W];

    // Register writes; reserved bits are masked so they stay zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            u_gain_low_q <= REG_RESET;
            v_gain_low_q <= REG_RESET;
            gain_high_q <= REG_RESET;
            luma_offset_low_q <= REG_RESET;
            offset_msb_q <= REG_RESET;
            phase_low_q <= REG_RESET;
            phase_high_q <= REG_RESET;
            grab_control_q <= REG_RESET;
            pixel_num_low_q <= REG_RESET;
            line_num_low_q <= REG_RESET;
            grab_num_high_q <= REG_RESET;
        end else if (ce && reg_write) begin
            case (reg_addr)
                ADDR_U_GAIN_LOW: begin
                    u_gain_low_q <= reg_wdata;
                end
                ADDR_V_GAIN_LOW: begin
                    v_gain_low_q <= reg_wdata;
                end
                ADDR_GAIN_HIGH: begin
                    gain_high_q <= reg_wdata & GAIN_HIGH_MASK;
                end
                ADDR_LUMA_OFFSET_LOW: begin
                    luma_offset_low_q <= reg_wdata;
                end
                ADDR_OFFSET_MSB: begin
                    offset_msb_q <= reg_wdata & OFFSET_MSB_MASK;
                end
                ADDR_PHASE_LOW: begin
                    phase_low_q <= reg_wdata;
                end
                ADDR_PHASE_HIGH: begin
                    phase_high_q <= reg_wdata;
                end
                ADDR_GRAB_CONTROL: begin
                    grab_control_q <= reg_wdata & GRAB_CONTROL_MASK;
                end
                ADDR_PIXEL_NUM_LOW: begin
                    pixel_num_low_q <= reg_wdata;
                end
                ADDR_LINE_NUM_LOW: begin
                    line_num_low_q <= reg_wdata;
                end
                ADDR_GRAB_NUM_HIGH: begin
                    grab_num_high_q <= reg_wdata & GRAB_NUM_HIGH_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Coefficient assembly
    always_comb begin
        coef_d = '0;
        coef_d.u_channel_gain = {gain_high_q[GH_U_LSB +: 3], u_gain_low_q};
        coef_d.v_channel_gain = {gain_high_q[GH_V_LSB +: 2], v_gain_low_q};
        coef_d.luma_gain = {gain_high_q[GH_LUMA_LSB +: 2], luma_gain_low};
        coef_d.luma_offset = {offset_msb_q[OM_OFFSET_MSB_BIT], luma_offset_low_q};
        coef_d.mixed_sync_gain = {offset_msb_q[OM_SYNC_LSB +: 2], mixed_sync_gain_low};
        coef_d.system_phase_offset = {phase_high_q, phase_low_q[PL_PHASE_LSB +: 7]};
        coef_d.v_axis_flip = phase_low_q[PL_VFLIP_BIT];
    end

    // Set drives zero while the other bank is in use
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            coef_q <= '0;
        end else if (ce) begin
            coef_q <= bank_select ? coef_d : '0;
        end
    end

    assign coef_set = coef_q;
    assign coef_set_active = bank_select;

    // Internal decodes
    assign line_decode = line_start && (line_count == line_grab_number)
        && (field_count == field_grab_number);
    assign pixel_decode = (pixel_count == pixel_grab_number);

    grab_pulse_select u_line_pulse (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .ext_select(external_line_grab_select),
        .strobe_pin(grab_strobe),
        .internal_pulse(line_decode),
        .pulse(line_pulse)
    );

    grab_pulse_select u_pixel_pulse (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .ext_select(external_pixel_grab_select),
        .strobe_pin(grab_strobe),
        .internal_pulse(pixel_decode),
        .pulse(pixel_pulse)
    );

    // Freeze only when enabled and no grab is pending
    assign freeze_grab = line_pulse && line_freeze_enable && !line_grab_flag_q;
    assign flag_clear = reg_write && (reg_addr == ADDR_GRAB_CONTROL) && !reg_wdata[GC_FLAG_BIT];

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_grab_flag_q <= 1'b0;
        end else if (ce) begin
            if (freeze_grab) begin
                line_grab_flag_q <= 1'b1;
            end else if (flag_clear) begin
                line_grab_flag_q <= 1'b0;
            end
        end
    end

    // Loop state of the frozen line
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frozen_q <= '0;
        end else if (ce && freeze_grab) begin
            frozen_q <= loop_state;
        end
    end

    assign frozen_loop_state = frozen_q;
    assign line_store_freeze = line_grab_flag_q && line_freeze_enable;
    // Dropping the enable releases the loops even with the flag still set
    assign synth_reload = ce && line_start && line_grab_flag_q && line_freeze_enable;

    // Grabbed-line window for the pixel gate: from line pulse to next line start
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_window_q <= 1'b0;
        end else if (ce) begin
            if (line_pulse) begin
                line_window_q <= 1'b1;
            end else if (line_start) begin
                line_window_q <= 1'b0;
            end
        end
    end

    assign pixel_capture = pixel_capture_enable && pixel_pulse
        && (!pixel_grab_gate || line_window_q || line_pulse);

    pixel_sample_store u_store (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .capture(pixel_capture),
        .sample_in(video_sample),
        .sample_q(held)
    );

    // Read mux; results are read only
    always_comb begin
        read_d = 8'h00;
        case (reg_addr)
            ADDR_U_GAIN_LOW: read_d = u_gain_low_q;
            ADDR_V_GAIN_LOW: read_d = v_gain_low_q;
            ADDR_GAIN_HIGH: read_d = gain_high_q;
            ADDR_LUMA_OFFSET_LOW: read_d = luma_offset_low_q;
            ADDR_OFFSET_MSB: read_d = offset_msb_q;
            ADDR_PHASE_LOW: read_d = phase_low_q;
            ADDR_PHASE_HIGH: read_d = phase_high_q;
            ADDR_GRAB_CONTROL: begin
                read_d = grab_control_q;
                read_d[GC_FLAG_BIT] = line_grab_flag_q;
            end
            ADDR_PIXEL_NUM_LOW: read_d = pixel_num_low_q;
            ADDR_LINE_NUM_LOW: read_d = line_num_low_q;
            ADDR_GRAB_NUM_HIGH: read_d = grab_num_high_q;
            ADDR_RES_GY: read_d = held.gy[9:2];
            ADDR_RES_BU: read_d = held.bu[9:2];
            ADDR_RES_RV: read_d = held.rv[9:2];
            ADDR_RES_RGB_LSB: read_d = {2'b00, held.gy[1:0], held.bu[1:0], held.rv[1:0]};
            ADDR_RES_LUMA: read_d = held.luma[9:2];
            ADDR_RES_MSYNC: read_d = held.msync[9:2];
            ADDR_RES_U: read_d = held.u[9:2];
            ADDR_RES_V: read_d = held.v[9:2];
            ADDR_RES_YUV_LSB: read_d = {held.luma[1:0], held.msync[1:0], held.u[1:0], held.v[1:0]};
            default: read_d = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (ce) begin
            rdata_q <= reg_read ? read_d : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    AST_FLAG_SET: assert property (ce && freeze_grab |=> line_grab_flag_q)
        else $error("line grab flag not set after a freeze");
    AST_NO_REGRAB: assert property (line_grab_flag_q && line_pulse |=> $stable(frozen_loop_state))
        else $error("second line grabbed while flag pending");
    AST_FLAG_CLEAR: assert property (ce && flag_clear && !freeze_grab |=> !line_grab_flag_q)
        else $error("flag not cleared by software write");
    AST_FREEZE_STATE: assert property (ce && freeze_grab |=> frozen_loop_state == $past(loop_state))
        else $error("loop state not stored on freeze");
    AST_NO_FREEZE_DISABLED: assert property (!line_freeze_enable |-> !line_store_freeze && !synth_reload)
        else $error("freeze active with enable low");
    AST_CAPTURE_ONLY_ENABLED: assert property (!pixel_capture_enable |=> $stable(held))
        else $error("pixel captured without enable");
    AST_GATED_CAPTURE: assert property (pixel_grab_gate && !line_window_q && !line_pulse |=> $stable(held))
        else $error("gated pixel capture outside grabbed line");
    AST_BANK_LOW: assert property (ce && !bank_select |=> coef_set == '0)
        else $error("coefficients driven with bank select low");
    AST_U_GAIN: assert property (ce && bank_select |=>
        coef_set.u_channel_gain[7:0] == $past(u_gain_low_q)
        && coef_set.u_channel_gain[10:8] == 3'($past(gain_high_q) >> GH_U_LSB))
        else $error("u gain assembled wrongly");
    AST_RESERVED_ZERO: assert property (ce && reg_read && reg_addr == ADDR_OFFSET_MSB |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved bits read nonzero");
    AST_READ_ONE_CYCLE: assert property (ce && !reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");

endmodule

// [dv/tb_top.sv]
/*
 * Self-checking bench for the coefficient set and grab control registers.
 * Assumes the package constants and the one-cycle read latency of the port.
 */
module tb_top
    import grab_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic bank_select = 1'b0;
    logic grab_strobe = 1'b0;
    logic line_start = 1'b0;
    logic [LINE_NUM_W-1:0] line_count = '0;
    logic [FIELD_NUM_W-1:0] field_count = '0;
    logic [PIX_NUM_W-1:0] pixel_count = '0;
    loop_state_t loop_state = '0;
    grab_sample_t video_sample = '0;
    coef_set_t coef_set;
    logic coef_set_active;
    logic line_store_freeze;
    logic synth_reload;
    loop_state_t frozen_loop_state;
    int miscompares = 0;
    int check_count = 0;
    logic [7:0] a;
    localparam grab_sample_t S1 = {10'h3a5, 10'h1c3, 10'h2f0, 10'h155, 10'h0aa, 10'h301, 10'h0ff};
    localparam grab_sample_t S2 = {10'h16a, 10'h2d2, 10'h0c9, 10'h3f0, 10'h20f, 10'h11e, 10'h0e1};

    always #10 core_clk = ~core_clk;

    scaler_phase_and_grab_registers i_scaler_phase_and_grab_registers (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .luma_gain_low(8'h12), .mixed_sync_gain_low(8'h34),
        .bank_select(bank_select), .grab_strobe(grab_strobe),
        .line_start(line_start), .line_count(line_count), .field_count(field_count),
        .pixel_count(pixel_count), .loop_state(loop_state), .video_sample(video_sample),
        .coef_set(coef_set), .coef_set_active(coef_set_active),
        .line_store_freeze(line_store_freeze), .synth_reload(synth_reload),
        .frozen_loop_state(frozen_loop_state)
    );

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // One line_start cycle with the given position
    task automatic line_pulse(input logic [8:0] ln);
        @(posedge core_clk);
        line_count <= ln;
        line_start <= 1'b1;
        @(posedge core_clk);
        line_start <= 1'b0;
        #1;
    endtask

    // Internal pixel decode matches for exactly one cycle
    task automatic pix_pulse(input grab_sample_t s);
        @(posedge core_clk);
        video_sample <= s;
        pixel_count <= 11'h277;
        @(posedge core_clk);
        pixel_count <= 11'h000;
        #1;
    endtask

    function automatic logic [7:0] res(input logic [7:0] ad, input grab_sample_t s);
        case (ad)
            ADDR_RES_GY: res = s.gy[9:2];
            ADDR_RES_BU: res = s.bu[9:2];
            ADDR_RES_RV: res = s.rv[9:2];
            ADDR_RES_RGB_LSB: res = {2'b00, s.gy[1:0], s.bu[1:0], s.rv[1:0]};
            ADDR_RES_LUMA: res = s.luma[9:2];
            ADDR_RES_MSYNC: res = s.msync[9:2];
            ADDR_RES_U: res = s.u[9:2];
            ADDR_RES_V: res = s.v[9:2];
            ADDR_RES_YUV_LSB: res = {s.luma[1:0], s.msync[1:0], s.u[1:0], s.v[1:0]};
            default: res = 8'h00;
        endcase
    endfunction

    task automatic test_coef();
        bank_select <= 1'b1;
        wr(ADDR_U_GAIN_LOW, 8'ha5);
        wr(ADDR_V_GAIN_LOW, 8'h3c);
        wr(ADDR_GAIN_HIGH, 8'ha9);
        wr(ADDR_LUMA_OFFSET_LOW, 8'h5a);
        wr(ADDR_OFFSET_MSB, 8'h06);
        wr(ADDR_PHASE_LOW, 8'hb7);
        wr(ADDR_PHASE_HIGH, 8'hc3);
        @(posedge core_clk);
        #1;
        chk(coef_set.luma_gain, {2'b10, 8'h12});
        chk(coef_set.u_channel_gain, {3'b101, 8'ha5});
        chk(coef_set.v_channel_gain, {2'b01, 8'h3c});
        chk(coef_set.mixed_sync_gain, {2'b10, 8'h34});
        chk(coef_set.luma_offset, {1'b1, 8'h5a});
        chk(coef_set.system_phase_offset, {8'hc3, 7'h5b});
        chk(coef_set.v_axis_flip, 1'b1);
        rd_chk(ADDR_GAIN_HIGH, 8'ha9);
        rd_chk(ADDR_OFFSET_MSB, 8'h06);
        rd_chk(8'h40, 8'h00);
        wr(ADDR_RES_GY, 8'hff);
        rd_chk(ADDR_RES_GY, 8'h00);
        // Enable low must swallow a write
        @(posedge core_clk);
        ce <= 1'b0;
        wr(ADDR_U_GAIN_LOW, 8'h5a);
        @(posedge core_clk);
        ce <= 1'b1;
        rd_chk(ADDR_U_GAIN_LOW, 8'ha5);
        @(posedge core_clk);
        bank_select <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(coef_set, '0);
        $display("test coef done");
    endtask

    task automatic test_line();
        wr(ADDR_PIXEL_NUM_LOW, 8'h77);
        wr(ADDR_LINE_NUM_LOW, 8'h21);
        wr(ADDR_GRAB_NUM_HIGH, 8'h5a);
        @(posedge core_clk);
        field_count <= 3'd5;
        wr(ADDR_GRAB_CONTROL, 8'h20);
        rd_chk(ADDR_GRAB_CONTROL, 8'h20);
        @(posedge core_clk);
        loop_state <= 32'hdead_beef;
        line_pulse(9'h120);
        chk(line_store_freeze, 1'b0);
        line_pulse(9'h121);
        chk(line_store_freeze, 1'b1);
        chk(frozen_loop_state, 32'hdead_beef);
        rd_chk(ADDR_GRAB_CONTROL, 8'h60);
        @(posedge core_clk);
        loop_state <= 32'h1234_5678;
        line_start <= 1'b1;
        #1;
        chk(synth_reload, 1'b1);
        @(posedge core_clk);
        line_start <= 1'b0;
        #1;
        chk(frozen_loop_state, 32'hdead_beef);
        wr(ADDR_GRAB_CONTROL, 8'h20);
        chk(line_store_freeze, 1'b0);
        wr(ADDR_GRAB_CONTROL, 8'h00);
        line_pulse(9'h121);
        rd_chk(ADDR_GRAB_CONTROL, 8'h00);
        wr(ADDR_GRAB_CONTROL, 8'h30);
        line_pulse(9'h121);
        chk(line_store_freeze, 1'b0);
        @(posedge core_clk);
        grab_strobe <= 1'b1;
        @(posedge core_clk);
        grab_strobe <= 1'b0;
        #1;
        chk(line_store_freeze, 1'b1);
        chk(frozen_loop_state, 32'h1234_5678);
        wr(ADDR_GRAB_CONTROL, 8'h00);
        $display("test line done");
    endtask

    task automatic test_pixel();
        wr(ADDR_GRAB_CONTROL, 8'h02);
        pix_pulse(S1);
        for (a = ADDR_RES_GY; a <= ADDR_RES_YUV_LSB; a++) begin
            rd_chk(a, res(a, S1));
        end
        wr(ADDR_GRAB_CONTROL, 8'h00);
        pix_pulse(S2);
        rd_chk(ADDR_RES_U, res(ADDR_RES_U, S1));
        wr(ADDR_GRAB_CONTROL, 8'h03);
        // Internal decode must be ignored: S2 would show if it were not
        pix_pulse(S2);
        rd_chk(ADDR_RES_GY, res(ADDR_RES_GY, S1));
        @(posedge core_clk);
        video_sample <= S2;
        grab_strobe <= 1'b1;
        @(posedge core_clk);
        grab_strobe <= 1'b0;
        rd_chk(ADDR_RES_V, res(ADDR_RES_V, S2));
        // Gate window closed by a non-matching line start
        wr(ADDR_GRAB_CONTROL, 8'h06);
        line_pulse(9'h000);
        pix_pulse(S1);
        rd_chk(ADDR_RES_LUMA, res(ADDR_RES_LUMA, S2));
        line_pulse(9'h121);
        pix_pulse(S1);
        rd_chk(ADDR_RES_LUMA, res(ADDR_RES_LUMA, S1));
        $display("test pixel done");
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        test_coef();
        test_line();
        test_pixel();
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        summarize();
    end
endmodule
